// File: sec_ctrl.sv
// APB-attached controller for a three-wire serial memory.
// Assumes one pclk domain and an external memory on cs/sk/data pins.
//
// What this block does
// - Unanswered operation aborts after 30 ms, goes idle, sets time-out.
// - Data pin held high means no time-out; busy clears at sequence end.
// - Only erase, erase-all, write, write-all wait for ready and time out.
// - Read-only loaded bit sets after successful power-up load or reload command.
// - Eight-bit address field, reset 00h, selects the memory byte.
// - Data register bits 7:0, reset 00h; bits 31:8 read zero.
// - Enable command permits later erase and write until disable.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sec_params.svh"
module sec_ctrl
  import sec_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SEC_TIMEOUT_CYC,
  parameter int SK_HALF     = `SEC_SK_HALF
)
(
  input  wire logic        pclk,       // System clock, 20 MHz.
  input  wire logic        presetn,    // Asynchronous reset, active low.
  input  wire logic        psel,       // APB select.
  input  wire logic        penable,    // APB enable.
  input  wire logic        pwrite,     // APB direction.
  input  wire logic [7:0]  paddr,      // APB byte address.
  input  wire logic [31:0] pwdata,     // APB write data.
  output logic [31:0]      prdata,     // APB read data.
  output logic             pready,     // APB ready.
  output logic             pslverr,    // APB error.
  output logic             irq,        // Level interrupt.
  output logic             mem_cs,     // Memory chip select.
  output logic             mem_sk,     // Memory serial clock.
  output logic             serial_memory_data_pin_o,  // Data out.
  output logic             serial_memory_data_pin_oe, // Drive enable.
  input  wire logic        serial_memory_data_pin_i   // Data in.
);
  typedef enum logic [2:0] {S_IDLE, S_SHIFT, S_GAP, S_WAIT, S_DONE} sec_st_t;

  sec_st_t     st_q, st_d;
  logic        busy_q, busy_d;
  sec_cmd_t    cmd_q, cmd_d;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic        tmo_q, tmo_d;
  logic        loaded_q, loaded_d;
  logic [1:0]  ist_q, ist_d;
  logic [1:0]  imsk_q, imsk_d;
  logic [19:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  div_q, div_d;
  logic        sk_q, sk_d;
  logic [31:0] tmr_q, tmr_d;
  logic        boot_q, boot_d;
  logic        cs_q, cs_d;
  logic        dout_q, dout_d;
  logic        oe_q, oe_d;
  logic [31:0] rd_q, rd_d;
  logic        din;
  logic        wr_acc, rd_acc;
  logic        done_ev, tmo_ev;

  sec_pin_sync u_sec_pin_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (serial_memory_data_pin_i),
    .pin_sync (din)
  );

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Frame: start bit, 2-bit opcode, 8 address bits, 8 data bits.
  function automatic logic [19:0] frame(sec_cmd_t c, logic [7:0] a,
                                        logic [7:0] d);
    logic [1:0] op;
    logic [7:0] ad;
    op = 2'h0;
    ad = a;
    case (c)
      SEC_CMD_READ:  op = 2'h2;
      SEC_CMD_WRITE: op = 2'h1;
      SEC_CMD_ERASE: op = 2'h3;
      SEC_CMD_ERASE_WRITE_ENABLE_CMD:  ad = 8'hc0;
      SEC_CMD_EWDS:  ad = 8'h00;
      SEC_CMD_WRITE_ALL_CMD:  ad = 8'h40;
      SEC_CMD_ERASE_ALL_CMD:  ad = 8'h80;
      default:       op = 2'h2;
    endcase
    frame = {1'b1, op, ad, d, 1'b0};
  endfunction

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    st_d    = st_q;
    busy_d  = busy_q;
    cmd_d   = cmd_q;
    addr_d  = addr_q;
    data_d  = data_q;
    tmo_d   = tmo_q;
    loaded_d = loaded_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    div_d   = div_q;
    sk_d    = sk_q;
    tmr_d   = tmr_q;
    boot_d  = 1'b0;
    cs_d    = cs_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    done_ev = 1'b0;
    tmo_ev  = 1'b0;
    case (st_q)
      S_IDLE:
      begin
        // A command is only taken while idle.
        if (boot_q || (wr_acc && paddr == `SEC_OFF_CMD &&
            pwdata[`SEC_BIT_BUSY]))
        begin
          cmd_d  = boot_q ? SEC_CMD_RELOAD :
                   sec_cmd_t'(pwdata[`SEC_CMD_MSB:`SEC_CMD_LSB]);
          busy_d = 1'b1;
          tmo_d  = 1'b0;
          st_d   = S_SHIFT;
          cs_d   = 1'b1;
          oe_d   = 1'b1;
          cnt_d  = 5'd0;
          div_d  = 8'h00;
          tmr_d  = 32'h0;
          if (!boot_q)
          begin
            addr_d = pwdata[7:0];
          end
          sh_d = frame(boot_q ? SEC_CMD_RELOAD :
                       sec_cmd_t'(pwdata[`SEC_CMD_MSB:`SEC_CMD_LSB]),
                       boot_q ? 8'h00 : pwdata[7:0], data_q);
          // Data leads sk by half a period, so each bit is set up early.
          dout_d = sh_d[19];
          if (!boot_q && pwdata[`SEC_CMD_MSB:`SEC_CMD_LSB] ==
              SEC_CMD_RELOAD)
          begin
            loaded_d = 1'b0;
          end
        end
        else if (wr_acc && paddr == `SEC_OFF_CMD)
        begin
          addr_d = pwdata[7:0];
        end
        if (wr_acc && paddr == `SEC_OFF_DATA)
        begin
          data_d = pwdata[7:0];
        end
      end
      S_SHIFT:
      begin
        div_d = div_q + 8'h01;
        if (div_q == 8'(SK_HALF - 1))
        begin
          div_d = 8'h00;
          sk_d  = !sk_q;
          if (sk_q)
          begin
            sh_d   = {sh_q[18:0], 1'b0};
            dout_d = sh_q[18];
            cnt_d  = cnt_q + 5'd1;
            if (cmd_q == SEC_CMD_READ || cmd_q == SEC_CMD_RELOAD)
            begin
              data_d = {data_q[6:0], din};
            end
            if (cnt_q == 5'd18)
            begin
              st_d = S_GAP;
            end
          end
          else
          begin
            oe_d   = !((cmd_q == SEC_CMD_READ || cmd_q == SEC_CMD_RELOAD)
                       && cnt_q > 5'd10);
          end
        end
      end
      S_GAP:
      begin
        cs_d = 1'b0;
        oe_d = 1'b0;
        sk_d = 1'b0;
        // Only programming cycles wait for the ready answer. Select stays
        // low for this cycle, which starts the memory's program cycle.
        if (cmd_q == SEC_CMD_WRITE || cmd_q == SEC_CMD_WRITE_ALL_CMD ||
            cmd_q == SEC_CMD_ERASE || cmd_q == SEC_CMD_ERASE_ALL_CMD)
        begin
          st_d = S_WAIT;
        end
        else
        begin
          st_d = S_DONE;
        end
      end
      S_WAIT:
      begin
        tmr_d = tmr_q + 32'h1;
        cs_d  = 1'b1;
        // The synchroniser still shows the frame's last bits for a few
        // cycles, so the line only counts once they have drained.
        if (din && tmr_q >= `SEC_SETTLE_CYC)
        begin
          st_d = S_DONE;
        end
        else if (tmr_q >= 32'(TIMEOUT_CYC - 1))
        begin
          tmo_d  = 1'b1;
          tmo_ev = 1'b1;
          st_d   = S_IDLE;
          busy_d = 1'b0;
          cs_d   = 1'b0;
        end
      end
      S_DONE:
      begin
        cs_d    = 1'b0;
        busy_d  = 1'b0;
        done_ev = 1'b1;
        st_d    = S_IDLE;
        if (cmd_q == SEC_CMD_RELOAD)
        begin
          loaded_d = 1'b1;
        end
      end
      default:
      begin
        st_d = S_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Interrupt and read path
  // --------------------------------------------------------------
  always_comb
  begin
    ist_d  = ist_q;
    imsk_d = imsk_q;
    rd_d   = rd_q;
    if (rd_acc && paddr == `SEC_OFF_IRQ_STAT)
    begin
      // Only bits already handed out are cleared, so none is lost.
      ist_d = ist_q & ~rd_q[1:0];
    end
    // Set wins over the read-clear.
    ist_d = ist_d | {tmo_ev, done_ev};
    if (wr_acc && paddr == `SEC_OFF_IRQ_MASK)
    begin
      imsk_d = pwdata[1:0];
    end
    if (psel && !penable)
    begin
      case (paddr)
        `SEC_OFF_CMD:
          rd_d = {busy_q, cmd_q, 18'h0, tmo_q, loaded_q, addr_q};
        `SEC_OFF_DATA:     rd_d = {24'h0, data_q};
        `SEC_OFF_IRQ_STAT: rd_d = {30'h0, ist_q};
        `SEC_OFF_IRQ_MASK: rd_d = {30'h0, imsk_q};
        default:           rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q     <= S_IDLE;
      busy_q   <= 1'b0;
      cmd_q    <= SEC_CMD_READ;
      addr_q   <= `SEC_ADDR_RESET;
      data_q   <= `SEC_DATA_RESET;
      tmo_q    <= 1'b0;
      loaded_q <= 1'b0;
      ist_q    <= 2'h0;
      imsk_q   <= 2'h0;
      sh_q     <= 20'h0;
      cnt_q    <= 5'd0;
      div_q    <= 8'h00;
      sk_q     <= 1'b0;
      tmr_q    <= 32'h0;
      boot_q   <= 1'b1;
      cs_q     <= 1'b0;
      dout_q   <= 1'b0;
      oe_q     <= 1'b0;
      rd_q     <= 32'h0;
    end
    else
    begin
      st_q     <= st_d;
      busy_q   <= busy_d;
      cmd_q    <= cmd_d;
      addr_q   <= addr_d;
      data_q   <= data_d;
      tmo_q    <= tmo_d;
      loaded_q <= loaded_d;
      ist_q    <= ist_d;
      imsk_q   <= imsk_d;
      sh_q     <= sh_d;
      cnt_q    <= cnt_d;
      div_q    <= div_d;
      sk_q     <= sk_d;
      tmr_q    <= tmr_d;
      boot_q   <= boot_d;
      cs_q     <= cs_d;
      dout_q   <= dout_d;
      oe_q     <= oe_d;
      rd_q     <= rd_d;
    end
  end

  // Read data is captured in the setup cycle, so pready can stay high.
  assign prdata = rd_q;
  assign irq    = |(ist_q & imsk_q);
  assign mem_cs = cs_q;
  assign mem_sk = sk_q;
  assign serial_memory_data_pin_o  = dout_q;
  assign serial_memory_data_pin_oe = oe_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_busy_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && st_q != S_DONE && st_q != S_WAIT |=> busy_q)
    else $error("busy dropped mid sequence");
  chk_tmo_sets: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_ev |=> tmo_q && !busy_q && st_q == S_IDLE)
    else $error("time-out did not go idle");
  chk_tmo_only_prog: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_WAIT |-> cmd_q inside {SEC_CMD_WRITE, SEC_CMD_WRITE_ALL_CMD,
      SEC_CMD_ERASE, SEC_CMD_ERASE_ALL_CMD})
    else $error("non-programming command waits");
  chk_high_no_tmo: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_WAIT && din && tmr_q >= `SEC_SETTLE_CYC
    |=> st_q == S_DONE ##1 !busy_q)
    else $error("high line did not finish");
  chk_loaded_set: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_DONE && cmd_q == SEC_CMD_RELOAD |=> loaded_q)
    else $error("loaded bit not set");
  chk_addr_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `SEC_OFF_CMD && st_q == S_IDLE && !boot_q
    |=> addr_q == $past(pwdata[7:0]))
    else $error("address not stored");
  chk_data_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `SEC_OFF_DATA |-> prdata[31:8] == 24'h0)
    else $error("reserved data bits set");
  chk_erase_write_enable_cmd_frame: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_IDLE && st_d == S_SHIFT && cmd_d == SEC_CMD_ERASE_WRITE_ENABLE_CMD
    |=> sh_q[19:9] == 11'h4c0)
    else $error("enable frame wrong");
endmodule
`default_nettype wire

// File: sec_mem_model.sv
// Behavioural three-wire serial memory for the controller bench.
// Assumes frames of start bit, two opcode bits and eight address bits.
`timescale 1ns/10ps
`default_nettype none
module sec_mem_model
#(
  parameter int PROG_CYC = 20
)
(
  input  wire logic pclk,     // Bench clock.
  input  wire logic mem_cs,   // Chip select.
  input  wire logic mem_sk,   // Serial clock.
  input  wire logic din,      // Line level from controller.
  input  wire logic present,  // Memory fitted.
  output logic      drive,    // Model drives the line.
  output logic      dout      // Level the model drives.
);
  logic [10:0] sh_q;
  logic        ew_q = 1'b0;
  logic        cs_q = 1'b0;
  logic        sk_q = 1'b0;
  int          nb_q = 0;
  int          wt_q = 0;
  initial drive = 1'b0;
  initial dout = 1'b0;
  always @(posedge pclk)
  begin
    cs_q <= mem_cs;
    sk_q <= mem_sk;
    if (mem_cs && !cs_q)
      nb_q <= 0;
    if (mem_cs && mem_sk && !sk_q && nb_q < 11)
    begin
      sh_q <= {sh_q[9:0], din};
      nb_q <= nb_q + 1;
      if (nb_q == 0)
        drive <= 1'b0;
    end
    if (!mem_cs && cs_q && present && nb_q == 11)
    begin
      if (sh_q[9:8] == 2'b00 && sh_q[7:6] == 2'b11)
        ew_q <= 1'b1;
      if (sh_q[9:8] == 2'b00 && sh_q[7:6] == 2'b00)
        ew_q <= 1'b0;
      // A locked memory stays silent, so the line falls to its pull.
      if (ew_q && (sh_q[9] != sh_q[8] ? sh_q[8] : sh_q[9]
          || sh_q[7] != sh_q[6]))
      begin
        drive <= 1'b1;
        dout <= 1'b0;
        wt_q <= PROG_CYC;
      end
    end
    if (wt_q > 0)
      wt_q <= wt_q - 1;
    if (wt_q == 1)
      dout <= 1'b1;
  end
endmodule
`default_nettype wire

// File: sec_params.svh
// Offsets, field positions, reset values and timing counts for the
// serial memory controller.
// Assumes a 32-bit APB register bus and a 20 MHz pclk.
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

`define SEC_OFF_CMD      8'hb0
`define SEC_OFF_DATA     8'hb4
`define SEC_OFF_IRQ_STAT 8'hb8
`define SEC_OFF_IRQ_MASK 8'hbc

`define SEC_BIT_BUSY     31
`define SEC_CMD_LSB      28
`define SEC_CMD_MSB      30
`define SEC_BIT_TIMEOUT  9
`define SEC_BIT_LOADED   8

`define SEC_ADDR_RESET   8'h00
`define SEC_DATA_RESET   8'h00

`define SEC_CLK_HZ       20000000
`define SEC_TIMEOUT_MS   30
`define SEC_TIMEOUT_CYC  ((`SEC_CLK_HZ / 1000) * `SEC_TIMEOUT_MS)
`define SEC_SK_HALF      10
`define SEC_SETTLE_CYC   6

`endif

// File: sec_pin_sync.sv
// Three-stage synchroniser with agreement filter for the data pin.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module sec_pin_sync
(
  input  wire logic pclk,     // System clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic pin_in,   // Raw pin level.
  output logic      pin_sync  // Filtered level.
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb
  begin
    sh_d  = {sh_q[1:0], pin_in};
    lvl_d = lvl_q;
    // Stage 0 is only read by stage 1; stages 1 and 2 must agree.
    if (sh_q[1] == sh_q[2])
    begin
      lvl_d = sh_q[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_q  <= 3'h0;
      lvl_q <= 1'b0;
    end
    else
    begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign pin_sync = lvl_q;
endmodule
`default_nettype wire

// File: sec_pkg.sv
// Types shared by the serial memory controller.
// Assumes the offsets and counts come from sec_params.svh.
package sec_pkg;
  typedef enum logic [2:0]
  {
    SEC_CMD_READ,
    SEC_CMD_EWDS,
    SEC_CMD_ERASE_WRITE_ENABLE_CMD,
    SEC_CMD_WRITE,
    SEC_CMD_WRITE_ALL_CMD,
    SEC_CMD_ERASE,
    SEC_CMD_ERASE_ALL_CMD,
    SEC_CMD_RELOAD
  } sec_cmd_t;
endpackage

// File: test_serial_eeprom_controller.sv
// Self-checking bench for the serial memory controller.
// Assumes sec_ctrl, sec_mem_model and a 20 MHz pclk.
`timescale 1ns/10ps
`default_nettype none
`include "sec_params.svh"
`define CHK(nm, e, g) \
  num_checks++; \
  if ((g) !== (e)) \
  begin \
    n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end
module test_serial_eeprom_controller;
  logic        pclk, presetn, psel, penable, pwrite, pull, present;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, irq, mem_cs, mem_sk, pin_o, pin_oe;
  logic        drive, dout;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Controller wins the line; otherwise memory, otherwise the pull.
  wire logic   pin = pin_oe ? pin_o : (drive ? dout : pull);
  sec_ctrl #(.TIMEOUT_CYC(50), .SK_HALF(2)) u_sec_ctrl
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .mem_cs, .mem_sk,
    .serial_memory_data_pin_o(pin_o),
    .serial_memory_data_pin_oe(pin_oe),
    .serial_memory_data_pin_i(pin)
  );
  sec_mem_model u_sec_mem_model
  (
    .pclk, .mem_cs, .mem_sk, .din(pin), .present, .drive, .dout
  );
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    `CHK("pslverr", 1'b0, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    r = 32'h8000_0000;
    while (r[31] !== 1'b0 && k++ < 300)
      rd(`SEC_OFF_CMD, r);
    `CHK("busy", 1'b0, r[31])
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] a,
                     input logic tmo);
    wr(`SEC_OFF_CMD, {1'b1, c, 20'h0, a});
    wait_idle();
    `CHK("timeout", tmo, r[9])
    `CHK("address", a, r[7:0])
  endtask
  task automatic t_basic();
    rd(`SEC_OFF_DATA, r);
    `CHK("data rst", 32'h0, r)
    wait_idle();
    `CHK("loaded", 1'b1, r[8])
    `CHK("addr rst", 8'h00, r[7:0])
    wr(`SEC_OFF_DATA, 32'hffff_ffa5);
    rd(`SEC_OFF_DATA, r);
    `CHK("data", 32'h0000_00a5, r)
    rd(8'hc0, r);
    `CHK("unmapped", 32'h0, r)
    $display("done t_basic");
  endtask
  task automatic t_absent();
    present <= 1'b0;
    for (int i = 0; i < 8; i++)
      cmd(i[2:0], 8'h20 + i[7:0], logic'(i >= 3 && i <= 6));
    pull <= 1'b1;
    cmd(3'd3, 8'h10, 1'b0);
    cmd(3'd6, 8'h11, 1'b0);
    pull <= 1'b0;
    wr(`SEC_OFF_CMD, 32'hb000_0033);
    wr(`SEC_OFF_CMD, 32'h8000_0044);
    wait_idle();
    `CHK("ignored", 8'h33, r[7:0])
    $display("done t_absent");
  endtask
  task automatic t_present();
    present <= 1'b1;
    cmd(3'd3, 8'h01, 1'b1);
    cmd(3'd2, 8'h00, 1'b0);
    cmd(3'd3, 8'h01, 1'b0);
    cmd(3'd5, 8'h02, 1'b0);
    cmd(3'd1, 8'h00, 1'b0);
    cmd(3'd3, 8'h01, 1'b1);
    $display("done t_present");
  endtask
  task automatic t_irq();
    rd(`SEC_OFF_IRQ_STAT, r);
    wr(`SEC_OFF_IRQ_MASK, 32'h2);
    rd(`SEC_OFF_IRQ_MASK, r);
    `CHK("mask", 32'h2, r)
    present <= 1'b0;
    cmd(3'd4, 8'h05, 1'b1);
    `CHK("irq up", 1'b1, irq)
    rd(`SEC_OFF_IRQ_STAT, r);
    `CHK("stat tmo", 1'b1, r[1])
    @(posedge pclk);
    `CHK("irq clr", 1'b0, irq)
    pull <= 1'b1;
    cmd(3'd0, 8'h06, 1'b0);
    `CHK("irq masked", 1'b0, irq)
    wr(`SEC_OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    `CHK("irq done", 1'b1, irq)
    $display("done t_irq");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, pull, present} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_basic();
    t_absent();
    t_present();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
